// ===== pll_post_counter.sv
`default_nettype none

// ****************************************************************
// shared constants and carriers
// ****************************************************************
package pll_scan_pkg;

  // one post-scale, feedback or pre-scale counter slot, first bit shifted at bit 0
  typedef struct packed {
    logic       odd;     // odd-divide duty select
    logic       bypass;  // divide by one
    logic [7:0] high;    // high-time count
    logic [7:0] low;     // low-time count
  } counter_cfg_t;

  // charge pump, vco divider and loop filter slot
  typedef struct packed {
    logic [6:0] spare;
    logic [4:0] resistor;   // loop filter resistor code
    logic [1:0] capacitor;  // loop filter capacitor code
    logic       k;          // vco post-scale divider
    logic [2:0] pump;       // charge pump current code
  } loop_cfg_t;

  // raw pins from the core side
  typedef struct packed {
    logic scanClk;
    logic enable;
    logic serialIn;
    logic loadPulse;
    logic vcoClk;
  } scan_pins_t;

  localparam int           CNT_BITS        = 18;
  localparam int           LOOP_BITS       = 18;
  localparam int           NUM_POST_DEF    = 7;
  localparam int           AXI_ADDR_W      = 8;
  localparam logic [7:0]   OFS_STATUS      = 8'h00;
  localparam logic [7:0]   OFS_CTRL        = 8'h04;
  localparam logic [7:0]   OFS_LOOP        = 8'h08;
  localparam logic [7:0]   OFS_MCNT        = 8'h0c;
  localparam logic [7:0]   OFS_NCNT        = 8'h10;
  localparam logic [1:0]   CNT_WINDOW      = 2'h2;   // address bits [7:6] of 0x80..0xbc
  localparam int           CTRL_UPD_EN_BIT = 0;
  localparam logic         CTRL_UPD_EN_RST = 1'h1;
  localparam int           STATUS_DONE_BIT = 0;
  localparam int           STATUS_PEND_LSB = 8;
  localparam logic [1:0]   RESP_OKAY       = 2'h0;
  localparam logic [1:0]   RESP_SLVERR     = 2'h2;
  localparam counter_cfg_t COUNTER_RESET   = counter_cfg_t'(18'h10000);
  localparam loop_cfg_t    LOOP_RESET      = loop_cfg_t'(18'h00000);
  localparam logic [8:0]   COUNT_ZERO_AS   = 9'h100;  // a count of zero means 256

endpackage : pll_scan_pkg

// ****************************************************************
// one post-scale output counter, half-cycle resolution
// ****************************************************************
module pll_post_counter
  import pll_scan_pkg::*;
(
  input  wire logic         sys_clk,
  input  wire logic         resetn,
  input  wire logic         vcoRise,
  input  wire logic         vcoFall,
  input  wire logic         vcoLevel,
  input  wire logic         loadReq,
  input  wire counter_cfg_t pending,
  output var  counter_cfg_t active,
  output logic              clkOut,
  output logic              loaded
);

  logic       running;
  logic       phaseHigh;
  logic [9:0] cnt;

  // half-cycle lengths of each phase
  wire logic [8:0] hiCnt    = (active.high == 8'h00) ? COUNT_ZERO_AS : {1'b0, active.high};
  wire logic [8:0] loCnt    = (active.low == 8'h00) ? COUNT_ZERO_AS : {1'b0, active.low};
  wire logic [9:0] hiHalf   = {hiCnt, 1'b0} - {9'h000, active.odd};
  wire logic [9:0] loHalf   = {loCnt, 1'b0} + {9'h000, active.odd};
  wire logic       vcoEdge  = vcoRise | vcoFall;
  wire logic       lastHigh = phaseHigh && (cnt == hiHalf - 10'h001);
  wire logic       lastLow  = !phaseHigh && (cnt == loHalf - 10'h001);
  // period boundary: next rising vco edge that starts a high phase
  wire logic       boundary = (active.bypass || !running) ? vcoRise : (vcoEdge && lastLow);
  wire logic       take     = loadReq && boundary;

  // bypass passes the vco through, else the divided phase
  assign clkOut = active.bypass ? vcoLevel : phaseHigh;

  // settings load and half-cycle counting
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      active    <= COUNTER_RESET;
      running   <= 1'b0;
      phaseHigh <= 1'b0;
      cnt       <= 10'h000;
      loaded    <= 1'b0;
    end else begin
      loaded <= take;
      if (take) begin
        active <= pending;
      end
      if (boundary) begin
        running   <= 1'b1;
        phaseHigh <= 1'b1;
        cnt       <= 10'h000;
      end else if (vcoEdge && running) begin
        if (lastHigh) begin
          phaseHigh <= 1'b0;
          cnt       <= 10'h000;
        end else begin
          cnt <= cnt + 10'h001;
        end
      end
    end
  end

  property p_even_fall;
    @(posedge sys_clk) disable iff (!resetn)
      ($fell(phaseHigh) && !$past(active.odd)) |-> $past(vcoRise);
  endproperty
  a_even_fall: assert property (p_even_fall) else $error("even divide fell off a rise");

  property p_odd_fall;
    @(posedge sys_clk) disable iff (!resetn)
      ($fell(phaseHigh) && $past(active.odd)) |-> $past(vcoFall);
  endproperty
  a_odd_fall: assert property (p_odd_fall) else $error("odd divide fell off a fall");

  property p_load_boundary;
    @(posedge sys_clk) disable iff (!resetn)
      loaded |-> (phaseHigh && cnt == 10'h000 && active == $past(pending));
  endproperty
  a_load_boundary: assert property (p_load_boundary) else $error("load off boundary");

endmodule : pll_post_counter

`default_nettype wire

// ===== pll_scan_chain_reconfig.sv
// The address map and the AXI4-Lite slave port were left to the implementer.
`default_nettype none

// Overview of operation
// - every post-scale counter divide and duty can change at run time via the chain
// - each post-scale counter holds an 8-bit high count and 8-bit low count
// - duty equals high or low time over period; period is high plus low
// - each counter also carries a bypass bit and an odd-divide bit
// - bypass set passes vco straight through; else divide by high plus low
// - odd bit clear makes the output fall on a vco rising edge
// - odd bit set gives 50% duty on odd divides, falling on vco falling edge
// - odd bit set: high time minus half cycle, low time plus half cycle
// - seven-counter chain is 180 bits; each counter slot is 18 bits
// - order is top C down to C0, M, N, pump, vco divider, filter, spare
// - first bit shifted is the low-count lsb of the top counter
// - last bit shifted is the msb of the spare field in the loop slot
// - ten-counter variant is 234 bits, starting at C9
// - seven-counter variants use 180 bits starting at C6
// - pump and filter codes change at run time; pump code 0, 1, 3 or 7
// - done output high while reconfiguring, falls when counters hold new settings
// - each counter takes new settings on its own period boundary

module pll_scan_chain_reconfig
  import pll_scan_pkg::*;
#(
  parameter int NUM_POST = NUM_POST_DEF  // 7 or 10 post-scale counters
) (
  input  wire logic                  sys_clk,
  input  wire logic                  resetn,
  input  wire logic                  scanClk,
  input  wire logic                  scan_clock_enable,
  input  wire logic                  scan_serial_in,
  input  wire logic                  config_load_pulse,
  input  wire logic                  vcoClk,
  output logic                       reconfig_done,
  output logic [NUM_POST-1:0]        clkOut,
  output var  counter_cfg_t          mCounter,
  output var  counter_cfg_t          nCounter,
  output logic [2:0]                 pump_current_code,
  output logic                       vcoPostDiv,
  output logic [1:0]                 filter_capacitor_code,
  output logic [4:0]                 filter_resistor_code,
  input  wire logic [AXI_ADDR_W-1:0] awaddr,
  input  wire logic                  awvalid,
  output logic                       awready,
  input  wire logic [31:0]           wdata,
  input  wire logic [3:0]            wstrb,
  input  wire logic                  wvalid,
  output logic                       wready,
  output logic [1:0]                 bresp,
  output logic                       bvalid,
  input  wire logic                  bready,
  input  wire logic [AXI_ADDR_W-1:0] araddr,
  input  wire logic                  arvalid,
  output logic                       arready,
  output logic [31:0]                rdata,
  output logic [1:0]                 rresp,
  output logic                       rvalid,
  input  wire logic                  rready
);

  // 180 bits for seven counters, 234 for ten
  localparam int LEN = (NUM_POST + 2) * CNT_BITS + LOOP_BITS;

  // ****************************************************************
  // pin synchronisers and edge detection
  // ****************************************************************
  scan_pins_t syncA;
  scan_pins_t syncB;
  logic       scanPrev;
  logic       vcoPrev;
  logic       loadPrev;

  wire scan_pins_t pinsIn = '{scanClk: scanClk, enable: scan_clock_enable,
                              serialIn: scan_serial_in, loadPulse: config_load_pulse,
                              vcoClk: vcoClk};

  // two flops on every pin, then previous copies for edges
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      syncA    <= scan_pins_t'(5'h00);
      syncB    <= scan_pins_t'(5'h00);
      scanPrev <= 1'b0;
      vcoPrev  <= 1'b0;
    end else begin
      syncA    <= pinsIn;
      syncB    <= syncA;
      scanPrev <= syncB.scanClk;
      vcoPrev  <= syncB.vcoClk;
    end
  end

  wire logic scanRise = syncB.scanClk && !scanPrev;
  wire logic vcoRise  = syncB.vcoClk && !vcoPrev;
  wire logic vcoFall  = !syncB.vcoClk && vcoPrev;
  wire logic shiftEn  = scanRise && syncB.enable;

  // ****************************************************************
  // scan chain
  // ****************************************************************
  logic [LEN-1:0] chain;

  // first bit shifted ends at bit 0, last at bit LEN-1
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      chain <= '0;
    end else if (shiftEn) begin
      chain <= {syncB.serialIn, chain[LEN-1:1]};
    end
  end

  // ****************************************************************
  // update capture and completion tracking
  // ****************************************************************
  logic                ctrlUpdEn;
  logic [NUM_POST-1:0] pendMask;
  logic [NUM_POST-1:0] loadedVec;
  counter_cfg_t        newCfg [NUM_POST];
  counter_cfg_t        activeCfg [NUM_POST];
  loop_cfg_t           loopCfg;

  // one update per load pulse, sampled on scan clock rises
  wire logic accept = scanRise && syncB.loadPulse && !loadPrev && ctrlUpdEn;
  wire loop_cfg_t    chainLoop = loop_cfg_t'(chain[LEN-1 -: LOOP_BITS]);
  wire counter_cfg_t chainM    = counter_cfg_t'(chain[NUM_POST*CNT_BITS +: CNT_BITS]);
  wire counter_cfg_t chainN    = counter_cfg_t'(chain[(NUM_POST+1)*CNT_BITS +: CNT_BITS]);
  // set on accept wins over counter acknowledgements
  wire logic [NUM_POST-1:0] next_pendMask = accept ? {NUM_POST{1'b1}} : (pendMask & ~loadedVec);

  // load pulse edge, pending counters and done flag
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      loadPrev      <= 1'b0;
      pendMask      <= '0;
      reconfig_done <= 1'b0;
    end else begin
      if (scanRise) begin
        loadPrev <= syncB.loadPulse;
      end
      pendMask      <= next_pendMask;
      reconfig_done <= |next_pendMask;
    end
  end

  // staged settings for counters, immediate ones for m, n and loop
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      mCounter <= COUNTER_RESET;
      nCounter <= COUNTER_RESET;
      loopCfg  <= LOOP_RESET;
      for (int i = 0; i < NUM_POST; i++) begin
        newCfg[i] <= COUNTER_RESET;
      end
    end else if (accept) begin
      mCounter <= chainM;
      nCounter <= chainN;
      loopCfg  <= chainLoop;
      for (int i = 0; i < NUM_POST; i++) begin
        newCfg[i] <= counter_cfg_t'(chain[(NUM_POST-1-i)*CNT_BITS +: CNT_BITS]);
      end
    end
  end

  assign pump_current_code     = loopCfg.pump;
  assign vcoPostDiv            = loopCfg.k;
  assign filter_capacitor_code = loopCfg.capacitor;
  assign filter_resistor_code  = loopCfg.resistor;

  // ****************************************************************
  // post-scale counters
  // ****************************************************************
  generate
    for (genvar i = 0; i < NUM_POST; i++) begin : g_cnt
      pll_post_counter u_cnt (
        .sys_clk  (sys_clk),
        .resetn   (resetn),
        .vcoRise  (vcoRise),
        .vcoFall  (vcoFall),
        .vcoLevel (vcoPrev),
        .loadReq  (pendMask[i]),
        .pending  (newCfg[i]),
        .active   (activeCfg[i]),
        .clkOut   (clkOut[i]),
        .loaded   (loadedVec[i])
      );
    end
  endgenerate

  // ****************************************************************
  // axi4-lite register slave
  // ****************************************************************
  logic                  awHeld;
  logic                  wHeld;
  logic [AXI_ADDR_W-1:0] wrAddr;
  logic [31:0]           wrData;
  logic [3:0]            wrStrb;
  logic [31:0]           cntWord [16];

  // read-back words per counter, spare slots zero
  generate
    for (genvar j = 0; j < 16; j++) begin : g_rd
      if (j < NUM_POST) begin : g_used
        assign cntWord[j] = {14'h0000, activeCfg[j]};
      end else begin : g_free
        assign cntWord[j] = 32'h0000_0000;
      end
    end
  endgenerate

  assign awready = !awHeld && !bvalid;
  assign wready  = !wHeld && !bvalid;
  assign arready = !rvalid;

  wire logic awFire  = awvalid && awready;
  wire logic wFire   = wvalid && wready;
  wire logic arFire  = arvalid && arready;
  wire logic doWrite = awHeld && wHeld && !bvalid;
  wire logic wrCtrl  = doWrite && (wrAddr == OFS_CTRL) && wrStrb[0];
  wire logic wrCnt   = (wrAddr[7:6] == CNT_WINDOW) && (wrAddr[1:0] == 2'h0)
                       && (32'(wrAddr[5:2]) < NUM_POST);
  wire logic wrMap   = (wrAddr == OFS_STATUS) || (wrAddr == OFS_CTRL) || (wrAddr == OFS_LOOP)
                       || (wrAddr == OFS_MCNT) || (wrAddr == OFS_NCNT) || wrCnt;
  wire logic rdCnt   = (araddr[7:6] == CNT_WINDOW) && (araddr[1:0] == 2'h0)
                       && (32'(araddr[5:2]) < NUM_POST);
  wire logic [31:0] statusWord = (32'(pendMask) << STATUS_PEND_LSB)
                                 | (32'(reconfig_done) << STATUS_DONE_BIT);
  wire logic [31:0] ctrlWord   = 32'(ctrlUpdEn) << CTRL_UPD_EN_BIT;
  wire logic rdMap   = (araddr == OFS_STATUS) || (araddr == OFS_CTRL) || (araddr == OFS_LOOP)
                       || (araddr == OFS_MCNT) || (araddr == OFS_NCNT) || rdCnt;
  wire logic [31:0] rdMux = (araddr == OFS_STATUS) ? statusWord :
                            (araddr == OFS_CTRL)   ? ctrlWord :
                            (araddr == OFS_LOOP)   ? {14'h0000, loopCfg} :
                            (araddr == OFS_MCNT)   ? {14'h0000, mCounter} :
                            (araddr == OFS_NCNT)   ? {14'h0000, nCounter} :
                            rdCnt                  ? cntWord[araddr[5:2]] : 32'h0000_0000;

  // write channel: address and data in either order, then response
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      awHeld <= 1'b0;
      wHeld  <= 1'b0;
      wrAddr <= '0;
      wrData <= 32'h0000_0000;
      wrStrb <= 4'h0;
      bvalid <= 1'b0;
      bresp  <= RESP_OKAY;
    end else begin
      if (awFire) begin
        awHeld <= 1'b1;
        wrAddr <= awaddr;
      end
      if (wFire) begin
        wHeld  <= 1'b1;
        wrData <= wdata;
        wrStrb <= wstrb;
      end
      if (doWrite) begin
        awHeld <= 1'b0;
        wHeld  <= 1'b0;
        bvalid <= 1'b1;
        bresp  <= wrMap ? RESP_OKAY : RESP_SLVERR;
      end else if (bvalid && bready) begin
        bvalid <= 1'b0;
      end
    end
  end

  // control register: update enable gate
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      ctrlUpdEn <= CTRL_UPD_EN_RST;
    end else if (wrCtrl) begin
      ctrlUpdEn <= wrData[CTRL_UPD_EN_BIT];
    end
  end

  // read channel: data registered one cycle after address
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      rvalid <= 1'b0;
      rdata  <= 32'h0000_0000;
      rresp  <= RESP_OKAY;
    end else if (arFire) begin
      rvalid <= 1'b1;
      rdata  <= rdMux;
      rresp  <= rdMap ? RESP_OKAY : RESP_SLVERR;
    end else if (rvalid && rready) begin
      rvalid <= 1'b0;
    end
  end

  // ****************************************************************
  // checks
  // ****************************************************************
  sequence s_accepted;
    accept ##1 reconfig_done;
  endsequence

  property p_shift;
    @(posedge sys_clk) disable iff (!resetn)
      shiftEn |=> (chain == {$past(syncB.serialIn), $past(chain[LEN-1:1])});
  endproperty
  a_shift: assert property (p_shift) else $error("chain did not shift one bit");

  property p_hold;
    @(posedge sys_clk) disable iff (!resetn)
      !shiftEn |=> (chain == $past(chain));
  endproperty
  a_hold: assert property (p_hold) else $error("chain moved without enable");

  property p_done_rise;
    @(posedge sys_clk) disable iff (!resetn)
      accept |-> s_accepted;
  endproperty
  a_done_rise: assert property (p_done_rise) else $error("done not raised by update");

  property p_done_fall;
    @(posedge sys_clk) disable iff (!resetn)
      $fell(reconfig_done) |-> (pendMask == '0 && $past(|loadedVec));
  endproperty
  a_done_fall: assert property (p_done_fall) else $error("done fell with counters pending");

  property p_first_bit;
    @(posedge sys_clk) disable iff (!resetn)
      accept |=> (newCfg[NUM_POST-1] == counter_cfg_t'($past(chain[CNT_BITS-1:0])));
  endproperty
  a_first_bit: assert property (p_first_bit) else $error("top counter slot misplaced");

  property p_loop_msb;
    @(posedge sys_clk) disable iff (!resetn)
      accept |=> (loopCfg == loop_cfg_t'($past(chain[LEN-1 -: LOOP_BITS])));
  endproperty
  a_loop_msb: assert property (p_loop_msb) else $error("loop settings misplaced");

  property p_bresp_hold;
    @(posedge sys_clk) disable iff (!resetn)
      (bvalid && !bready) |=> (bvalid && $stable(bresp));
  endproperty
  a_bresp_hold: assert property (p_bresp_hold) else $error("write response dropped");

  property p_no_update_gated;
    @(posedge sys_clk) disable iff (!resetn)
      (!ctrlUpdEn && !reconfig_done) |=> !reconfig_done;
  endproperty
  a_no_update_gated: assert property (p_no_update_gated) else $error("gated update ran");

endmodule : pll_scan_chain_reconfig

`default_nettype wire

// ===== pll_scan_chain_reconfig_tb_top.sv
`default_nettype none

// ****************************************************************
// self-checking bench for the scan chain block
// ****************************************************************
module pll_scan_chain_reconfig_tb_top import pll_scan_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;

  localparam int NP  = 7;
  localparam int LEN = 18 * NP + 54;
  logic sys_clk, resetn, vcoClk, scanClk, scanEn, scanIn, loadPulse, reconfig_done, doneQ;
  logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  logic                  vcoPostDiv;
  logic [NP-1:0]         clkOut;
  counter_cfg_t          mCounter, nCounter, mExp, nExp;
  counter_cfg_t          cfg [NP];
  loop_cfg_t             lp;
  logic [2:0]            pump_current_code;
  logic [1:0]            filter_capacitor_code, bresp, rresp, vcnt;
  logic [4:0]            filter_resistor_code;
  logic [AXI_ADDR_W-1:0] awaddr, araddr;
  logic [31:0]           wdata, rdata;
  logic [3:0]            wstrb;
  logic [233:0]          frame;
  logic [33:0]           rdQ [$];
  logic [1:0]            wrQ [$];
  logic [15:0]           seed;
  int                    nErrors, numChecks, doneRises;
  logic [4:0] resTab [11] = '{5'h00, 5'h03, 5'h04, 5'h08, 5'h10, 5'h13, 5'h14, 5'h18,
                              5'h1b, 5'h1c, 5'h1e};
  logic [2:0] pumpTab [4] = '{3'h0, 3'h1, 3'h3, 3'h7};
  logic [1:0] capTab [3] = '{2'h0, 2'h1, 2'h3};

  scan_loader i_scan_loader (.sys_clk(sys_clk), .scanClk(scanClk), .enable(scanEn),
    .serialIn(scanIn), .loadPulse(loadPulse));
  pll_scan_chain_reconfig #(.NUM_POST(NP)) i_pll_scan_chain_reconfig (.sys_clk, .resetn,
    .scanClk, .scan_clock_enable(scanEn), .scan_serial_in(scanIn),
    .config_load_pulse(loadPulse), .vcoClk, .reconfig_done, .clkOut, .mCounter, .nCounter,
    .pump_current_code, .vcoPostDiv, .filter_capacitor_code, .filter_resistor_code,
    .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready,
    .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready);

  // system clock, 100 ns period
  initial begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end

  // vco at one eighth of sys_clk; count rises of done
  always @(posedge sys_clk) begin
    vcnt  <= vcnt + 2'h1;
    doneQ <= reconfig_done;
    if (vcnt == 2'h3) vcoClk <= ~vcoClk;
    if (reconfig_done && !doneQ) doneRises++;
  end

  // each bus answer against the oldest note
  always @(posedge sys_clk) begin
    if (rvalid && rready) check("rdata", rdQ.pop_front(), {rresp, rdata});
    if (bvalid && bready) check("bresp", 34'(wrQ.pop_front()), 34'(bresp));
  end

  task automatic check(input string name, input logic [33:0] exp, input logic [33:0] got);
    numChecks++;
    if (got !== exp) begin
      nErrors++;
      $display("unexpected %s exp %h got %h", name, exp, got);
    end
  endtask

  task automatic finishTest();
    if (nErrors == 0 && numChecks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // one step of a bounded wait
  task automatic tick(inout int t);
    @(negedge sys_clk);
    t++;
    if (t > 20000) begin
      nErrors++;
      finishTest();
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    int t;
    logic aTk, wTk, bTk, bUp;
    t = 0;
    wrQ.push_back(r);
    @(posedge sys_clk);
    awaddr  <= a;
    wdata   <= d;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    do begin
      tick(t);
      aTk = awvalid && awready;
      wTk = wvalid && wready;
      bTk = bvalid && bready;
      bUp = bvalid;
      @(posedge sys_clk);
      if (aTk) awvalid <= 1'b0;
      if (wTk) wvalid <= 1'b0;
      if (bUp && !bTk) bready <= 1'b1;  // late ready: response must stand meanwhile
    end while (!bTk);
    bready <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [33:0] e);
    int t;
    logic aTk, rTk;
    t = 0;
    rdQ.push_back(e);
    @(posedge sys_clk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do begin
      tick(t);
      aTk = arvalid && arready;
      rTk = rvalid && rready;
      @(posedge sys_clk);
      if (aTk) arvalid <= 1'b0;
    end while (!rTk);
    rready <= 1'b0;
  endtask

  // every readable setting but the control word against the last accepted frame
  task automatic readAll();
    rd(OFS_STATUS, {RESP_OKAY, 32'h0});
    rd(OFS_MCNT, {RESP_OKAY, 14'h0, mExp});
    rd(OFS_NCNT, {RESP_OKAY, 14'h0, nExp});
    rd(OFS_LOOP, {RESP_OKAY, 14'h0, lp});
    for (int i = 0; i < NP; i++) begin
      rd(8'h80 + 8'(4 * i), {RESP_OKAY, 14'h0, cfg[i]});
    end
    check("mOut", 34'(mExp), 34'(mCounter));
    check("loopOut", 34'(lp[10:0]), 34'({filter_resistor_code, filter_capacitor_code,
      vcoPostDiv, pump_current_code}));
  endtask

  function automatic counter_cfg_t randCfg();
    logic [15:0] r;
    seed = {seed[14:0], seed[15] ^ seed[13] ^ seed[12] ^ seed[10]};
    r = seed;
    return '{r[9], r[8:6] == 3'h0, 8'(r[5:3]) + 8'h1, 8'(r[2:0]) + 8'h1};
  endfunction

  // main sequence
  initial begin
    int t, hi, lo, n0, ci;
    {resetn, awvalid, wvalid, bready, arvalid, rready, vcoClk, doneQ} = '0;
    {awaddr, araddr, wdata, vcnt} = '0;
    wstrb = 4'hf;
    seed = 16'h653c;
    {nErrors, numChecks, doneRises} = '0;
    {mExp, nExp, lp} = {COUNTER_RESET, COUNTER_RESET, LOOP_RESET};
    foreach (cfg[i]) cfg[i] = COUNTER_RESET;
    repeat (12) @(posedge sys_clk);
    resetn <= 1'b1;
    readAll();
    rd(OFS_CTRL, {RESP_OKAY, 32'h1});
    wr(8'h40, 32'hffffffff, RESP_SLVERR);
    wr(OFS_LOOP, 32'h7ff, RESP_OKAY);
    wr(OFS_CTRL, 32'h0, RESP_OKAY);
    frame = '1;
    frame[LEN-18 +: 18] = '0;
    i_scan_loader.load(frame, LEN, 0);
    repeat (30) @(posedge sys_clk);
    check("doneRises", 34'h0, 34'(doneRises));
    readAll();
    wr(OFS_CTRL, 32'h1, RESP_OKAY);
    for (int f = 0; f < 11; f++) begin
      foreach (cfg[i]) cfg[i] = randCfg();
      mExp = randCfg();
      nExp = randCfg();
      lp = '{7'h0, resTab[f], capTab[f % 3], seed[0], pumpTab[f % 4]};
      frame = '0;
      for (int i = 0; i < NP; i++) frame[18 * (NP - 1 - i) +: 18] = cfg[i];
      frame[18 * NP +: 54] = {lp, nExp, mExp};
      n0 = doneRises;
      t = 0;
      i_scan_loader.load(frame, LEN, (f % 2) * 3);
      while (reconfig_done !== 1'b0 || doneRises == n0) tick(t);
      check("doneRises", 34'(n0 + 1), 34'(doneRises));
      readAll();
      {t, hi, lo} = '0;
      ci = f % NP;
      while (clkOut[ci] !== 1'b0) tick(t);
      while (clkOut[ci] !== 1'b1) tick(t);
      while (clkOut[ci] === 1'b1) begin
        tick(t);
        hi++;
      end
      while (clkOut[ci] === 1'b0) begin
        tick(t);
        lo++;
      end
      check("clkHigh", cfg[ci].bypass ? 34'h4 : 34'((2 * cfg[ci].high - cfg[ci].odd) * 4),
        34'(hi));
      check("clkLow", cfg[ci].bypass ? 34'h4 : 34'((2 * cfg[ci].low + cfg[ci].odd) * 4),
        34'(lo));
    end
    finishTest();
  end
endmodule // pll_scan_chain_reconfig_tb_top

`default_nettype wire

// ===== scan_loader.sv
`default_nettype none

// ****************************************************************
// core-side loader: scan clock, enable, serial data, load pulse
// ****************************************************************
module scan_loader (
  input  wire logic sys_clk,
  output logic      scanClk,
  output logic      enable,
  output logic      serialIn,
  output logic      loadPulse
);
  timeunit 1ns;
  timeprecision 1ns;

  // pins idle, scan clock stands low outside frames
  initial begin
    scanClk   = 1'b0;
    enable    = 1'b0;
    serialIn  = 1'b0;
    loadPulse = 1'b0;
  end

  // one scan period: 4 sys_clk low, rise, 4 sys_clk high
  task automatic pulse();
    repeat (4) @(posedge sys_clk);
    scanClk <= 1'b1;
    repeat (4) @(posedge sys_clk);
    scanClk <= 1'b0;
  endtask

  // shift len bits, idle rises with enable low, then one load pulse
  task automatic load(input logic [233:0] frame, input int len, input int idle);
    @(posedge sys_clk);
    enable <= 1'b1;
    repeat (8) @(posedge sys_clk);
    for (int i = 0; i < len; i++) begin
      serialIn <= frame[i];
      pulse();
    end
    enable <= 1'b0;
    for (int i = 0; i < idle; i++) begin
      serialIn <= ~serialIn;
      pulse();
    end
    serialIn  <= ~serialIn;
    loadPulse <= 1'b1;
    pulse();
    loadPulse <= 1'b0;
  endtask
endmodule // scan_loader

`default_nettype wire
